// ---- hdl/pptab_defs.svh ----
// Offsets, field positions, reset values and sizes of the push/pop word table
`ifndef PPTAB_DEFS_SVH
`define PPTAB_DEFS_SVH

// ----------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------
`define PPTAB_DEPTH        16
`define PPTAB_WIDTH        32
`define PPTAB_ADDR_W       5
`define PPTAB_EV_W         5

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define PPTAB_OFS_CTRL     5'h00
`define PPTAB_OFS_PUSHVAL  5'h04
`define PPTAB_OFS_RESULT   5'h08
`define PPTAB_OFS_COUNT    5'h0c
`define PPTAB_OFS_FLAGS    5'h10
`define PPTAB_OFS_IRQ_ST   5'h14
`define PPTAB_OFS_IRQ_CLR  5'h18
`define PPTAB_OFS_IRQ_EN   5'h1c

// ----------------------------------------------------------------
// Event bits of status, clear and enable registers
// ----------------------------------------------------------------
`define PPTAB_EV_PUSH      0
`define PPTAB_EV_TAKE      1
`define PPTAB_EV_FULL_REF  2
`define PPTAB_EV_EMPTY_REF 3
`define PPTAB_EV_FLUSH     4

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define PPTAB_CTRL_RST     5'h00
`define PPTAB_PUSHVAL_RST  32'h0000_0000
`define PPTAB_IRQ_EN_RST   5'h00

`endif

// ---- hdl/pptab_pkg.sv ----
// Types shared by the push/pop word table modules
package pptab_pkg;

	// Coil levels, also used for their rising-edge pulses
	typedef struct packed {
		logic flush_pulse;
		logic take_newest_pulse;
		logic take_oldest_pulse;
		logic push_pulse;
		logic block_activation;
	} pptab_coil_s;

	// Engine state: fetch means a popped word is on its way
	typedef enum logic [0:0] {
		PPTAB_IDLE  = 1'b0,
		PPTAB_FETCH = 1'b1
	} pptab_state_e;

	// Table fill flags
	typedef struct packed {
		logic full_flag;
		logic empty_flag;
	} pptab_flags_s;

endpackage

// ---- hdl/pptab_edge.sv ----
// Coil edge detector: one-cycle pulse on each rising coil level
`timescale 1ns/1ps
module pptab_edge (
	input  wire logic                 clk,
	input  wire logic                 rst_n,
	input  wire pptab_pkg::pptab_coil_s lvl,
	output      pptab_pkg::pptab_coil_s rise
);
	import pptab_pkg::*;

	typedef struct packed {
		pptab_coil_s prev;
		pptab_coil_s rise;
	} pptab_edge_s;

	pptab_edge_s s_q;
	pptab_edge_s s_d;

	// Compare with the level of the previous cycle
	always_comb begin
		s_d      = s_q;
		s_d.prev = lvl;
		s_d.rise = lvl & ~s_q.prev;
	end

	// State register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign rise = s_q.rise;
endmodule

// ---- hdl/pptab_mem.sv ----
// Small word memory with one write port and a registered read port
`timescale 1ns/1ps
module pptab_mem #(
	parameter int unsigned WIDTH = 32,
	parameter int unsigned DEPTH = 16,
	parameter int unsigned AW    = 4
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             we,
	input  wire logic [AW-1:0]    waddr,
	input  wire logic [WIDTH-1:0] wdata,
	input  wire logic             re,
	input  wire logic [AW-1:0]    raddr,
	output      logic [WIDTH-1:0] rdata
);
	import pptab_pkg::*;

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] cells;
		logic [WIDTH-1:0]            rdata;
	} pptab_mem_s;

	pptab_mem_s s_q;
	pptab_mem_s s_d;

	// Write and read; words are stored bit for bit
	always_comb begin
		s_d = s_q;
		if (we) begin
			s_d.cells[waddr] = wdata;
		end
		if (re) begin
			s_d.rdata = s_q.cells[raddr];
		end
	end

	// State register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign rdata = s_q.rdata;
endmodule

// ---- hdl/pptab_table.sv ----
// Push/pop word table with Avalon-MM register access
//
// Chosen here: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "pptab_defs.svh"
module pptab_table #(
	parameter int unsigned WIDTH = `PPTAB_WIDTH,
	parameter int unsigned DEPTH = `PPTAB_DEPTH,
	parameter int unsigned AW    = $clog2(DEPTH),
	parameter int unsigned CW    = $clog2(DEPTH + 1)
) (
	input  wire logic                     CLOCK,
	input  wire logic                     RST_N,
	input  wire logic [`PPTAB_ADDR_W-1:0] AVS_ADDRESS,
	input  wire logic                     AVS_READ,
	input  wire logic                     AVS_WRITE,
	input  wire logic [31:0]              AVS_WRITEDATA,
	input  wire logic [3:0]               AVS_BYTEENABLE,
	output      logic [31:0]              AVS_READDATA,
	output      logic                     AVS_WAITREQUEST,
	output      logic                     IRQ,
	output      logic [WIDTH-1:0]         RESULT_OUT,
	output      logic [CW-1:0]            ENTRY_COUNT,
	output      logic                     EMPTY_FLAG,
	output      logic                     FULL_FLAG
);
	import pptab_pkg::*;

	// Assertions of this module all run on the one clock
	default clocking cb @(posedge CLOCK);
	endclocking
	default disable iff (!RST_N);

	// ----------------------------------------------------------------
	// Elaboration checks
	// ----------------------------------------------------------------
	if (WIDTH < 1 || WIDTH > 32 || DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad
		$error("width must be 1..32 and depth a power of two");
	end

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		pptab_state_e           st;
		logic [AW-1:0]          head;
		logic [CW-1:0]          cnt;
		logic [WIDTH-1:0]       result;
		pptab_flags_s           flags;
		pptab_coil_s            ctrl;
		logic [31:0]            push_val;
		logic [`PPTAB_EV_W-1:0] irq_st;
		logic [`PPTAB_EV_W-1:0] irq_en;
		logic                   irq;
		logic                   wait_req;
		logic [31:0]            rdata;
	} pptab_core_s;

	pptab_core_s s_q;
	pptab_core_s s_d;

	pptab_coil_s            rise;
	logic                   act;
	logic                   do_flush;
	logic                   do_push;
	logic                   do_oldest;
	logic                   do_newest;
	logic                   do_take;
	logic                   mem_we;
	logic                   mem_re;
	logic [AW-1:0]          mem_waddr;
	logic [AW-1:0]          mem_raddr;
	logic [WIDTH-1:0]       mem_rdata;
	logic [`PPTAB_EV_W-1:0] ev;
	logic [`PPTAB_EV_W-1:0] clr;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Byte-lane merge of a write into a stored word
	function automatic logic [31:0] be_merge(
		input logic [31:0] old,
		input logic [31:0] wr,
		input logic [3:0]  be
	);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[8*i +: 8] = wr[8*i +: 8];
			end
		end
		return r;
	endfunction

	// Register read mux; every word slot of the window except the interrupt clear slot is mapped
	function automatic logic [31:0] reg_read(
		input pptab_core_s            s,
		input logic [`PPTAB_ADDR_W-1:0] a
	);
		logic [31:0] r;
		r = 32'h0000_0000;
		case ({a[`PPTAB_ADDR_W-1:2], 2'b00})
			`PPTAB_OFS_CTRL:    r = 32'(s.ctrl);
			`PPTAB_OFS_PUSHVAL: r = s.push_val;
			`PPTAB_OFS_RESULT:  r = 32'($signed(s.result));
			`PPTAB_OFS_COUNT:   r = 32'(s.cnt);
			`PPTAB_OFS_FLAGS:   r = {29'h0, s.st == PPTAB_FETCH, s.flags};
			`PPTAB_OFS_IRQ_ST:  r = 32'(s.irq_st);
			`PPTAB_OFS_IRQ_EN:  r = 32'(s.irq_en);
			default:            r = 32'h0000_0000;
		endcase
		return r;
	endfunction

	// ----------------------------------------------------------------
	// Coil edges and memory
	// ----------------------------------------------------------------
	pptab_edge u_edge (
		.clk   (CLOCK),
		.rst_n (RST_N),
		.lvl   (s_q.ctrl),
		.rise  (rise)
	);

	pptab_mem #(
		.WIDTH (WIDTH),
		.DEPTH (DEPTH),
		.AW    (AW)
	) u_mem (
		.clk   (CLOCK),
		.rst_n (RST_N),
		.we    (mem_we),
		.waddr (mem_waddr),
		.wdata (s_q.push_val[WIDTH-1:0]),
		.re    (mem_re),
		.raddr (mem_raddr),
		.rdata (mem_rdata)
	);

	// Operation select; flush beats push beats oldest beats newest
	assign act       = s_q.ctrl.block_activation;
	assign do_flush  = act && rise.flush_pulse;
	assign do_push   = act && !do_flush && rise.push_pulse && !s_q.flags.full_flag;
	assign do_oldest = act && !do_flush && !rise.push_pulse && rise.take_oldest_pulse
		&& !s_q.flags.empty_flag;
	assign do_newest = act && !do_flush && !rise.push_pulse && !rise.take_oldest_pulse
		&& rise.take_newest_pulse && !s_q.flags.empty_flag;
	assign do_take   = do_oldest || do_newest;

	// Memory addresses: append behind newest, read oldest or newest
	assign mem_we    = do_push;
	assign mem_waddr = s_q.head + s_q.cnt[AW-1:0];
	assign mem_re    = do_take;
	assign mem_raddr = do_oldest ? s_q.head : AW'(s_q.head + s_q.cnt[AW-1:0] - AW'(1));

	// Events for the interrupt status
	always_comb begin
		ev                        = '0;
		ev[`PPTAB_EV_PUSH]        = do_push;
		ev[`PPTAB_EV_TAKE]        = do_take;
		ev[`PPTAB_EV_FULL_REF]    = act && !do_flush && rise.push_pulse && s_q.flags.full_flag;
		ev[`PPTAB_EV_EMPTY_REF]   = act && !do_flush && !rise.push_pulse
			&& (rise.take_oldest_pulse || rise.take_newest_pulse) && s_q.flags.empty_flag;
		ev[`PPTAB_EV_FLUSH]       = do_flush;
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		clr = '0;
		// Bus: drop waitrequest one cycle, act at that edge
		if (!s_q.wait_req) begin
			s_d.wait_req = 1'b1;
			if (AVS_WRITE) begin
				case ({AVS_ADDRESS[`PPTAB_ADDR_W-1:2], 2'b00})
					`PPTAB_OFS_CTRL: begin
						s_d.ctrl = pptab_coil_s'(5'(be_merge(32'(s_q.ctrl), AVS_WRITEDATA,
							AVS_BYTEENABLE)));
					end
					`PPTAB_OFS_PUSHVAL: begin
						s_d.push_val = be_merge(s_q.push_val, AVS_WRITEDATA, AVS_BYTEENABLE);
					end
					`PPTAB_OFS_IRQ_CLR: begin
						clr = AVS_BYTEENABLE[0] ? AVS_WRITEDATA[`PPTAB_EV_W-1:0] : '0;
					end
					`PPTAB_OFS_IRQ_EN: begin
						s_d.irq_en = AVS_BYTEENABLE[0] ? AVS_WRITEDATA[`PPTAB_EV_W-1:0]
							: s_q.irq_en;
					end
					default: begin
					end
				endcase
			end
		end else if (AVS_READ || AVS_WRITE) begin
			s_d.wait_req = 1'b0;
			s_d.rdata    = reg_read(s_q, AVS_ADDRESS);
		end
		// Popped word arrives from the memory
		case (s_q.st)
			PPTAB_FETCH: begin
				s_d.result = mem_rdata;
				s_d.st     = PPTAB_IDLE;
			end
			PPTAB_IDLE: begin
			end
			default: begin
				s_d.st = PPTAB_IDLE;
			end
		endcase
		// Table operations
		if (do_flush) begin
			s_d.cnt  = '0;
			s_d.head = '0;
			s_d.st   = PPTAB_IDLE;
		end else if (do_push) begin
			s_d.cnt    = CW'(s_q.cnt + CW'(1));
			s_d.result = s_q.push_val[WIDTH-1:0];
			s_d.st     = PPTAB_IDLE;
		end else if (do_take) begin
			s_d.cnt = CW'(s_q.cnt - CW'(1));
			s_d.st  = PPTAB_FETCH;
			if (do_oldest) begin
				s_d.head = AW'(s_q.head + AW'(1));
			end
		end
		// Flags follow the count exactly
		s_d.flags.empty_flag = (s_d.cnt == '0);
		s_d.flags.full_flag  = (s_d.cnt == CW'(DEPTH));
		// Sticky status, a new event wins over a clear
		s_d.irq_st = (s_q.irq_st & ~clr) | ev;
		s_d.irq    = |(s_d.irq_st & s_d.irq_en);
	end

	// State register
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			s_q                  <= '0;
			s_q.ctrl             <= pptab_coil_s'(`PPTAB_CTRL_RST);
			s_q.push_val         <= `PPTAB_PUSHVAL_RST;
			s_q.irq_en           <= `PPTAB_IRQ_EN_RST;
			s_q.flags.empty_flag <= 1'b1;
			s_q.wait_req         <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign AVS_READDATA    = s_q.rdata;
	assign AVS_WAITREQUEST = s_q.wait_req;
	assign IRQ             = s_q.irq;
	assign RESULT_OUT      = s_q.result;
	assign ENTRY_COUNT     = s_q.cnt;
	assign EMPTY_FLAG      = s_q.flags.empty_flag;
	assign FULL_FLAG       = s_q.flags.full_flag;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	a_count_range: assert property (ENTRY_COUNT <= CW'(DEPTH))
		else $error("entry count above depth");
	a_empty_exact: assert property (EMPTY_FLAG == (ENTRY_COUNT == '0))
		else $error("empty flag disagrees with count");
	a_full_exact: assert property (FULL_FLAG == (ENTRY_COUNT == CW'(DEPTH)))
		else $error("full flag disagrees with count");
	a_idle_disabled: assert property (!s_q.ctrl.block_activation |=> $stable(ENTRY_COUNT))
		else $error("count moved while inactive");
	a_push_count: assert property (do_push |=> ENTRY_COUNT == $past(ENTRY_COUNT) + CW'(1))
		else $error("push did not add one entry");
	a_push_result: assert property (do_push |=> RESULT_OUT == $past(s_q.push_val[WIDTH-1:0]))
		else $error("push did not show written word");
	a_full_refuse: assert property (act && rise.push_pulse && !rise.flush_pulse && FULL_FLAG
		|=> $stable(ENTRY_COUNT) && FULL_FLAG)
		else $error("push accepted on a full table");
	a_flush_zero: assert property (do_flush |=> ENTRY_COUNT == '0 && EMPTY_FLAG && !FULL_FLAG)
		else $error("flush did not empty table");
	a_take_count: assert property (do_take |=> ENTRY_COUNT == $past(ENTRY_COUNT) - CW'(1))
		else $error("take did not remove one entry");
	a_take_result: assert property (do_take ##1 !do_push && !do_flush
		|=> RESULT_OUT == $past(mem_rdata))
		else $error("taken word not shown on result");
	a_empty_take: assert property (ev[`PPTAB_EV_EMPTY_REF] && s_q.st == PPTAB_IDLE
		|=> $stable(ENTRY_COUNT) && $stable(RESULT_OUT))
		else $error("take on empty table changed state");
	a_irq_level: assert property (IRQ == |(s_q.irq_st & s_q.irq_en))
		else $error("interrupt output disagrees with status");
endmodule

// ---- tb/pptab_host.sv ----
// Avalon-MM master model standing for the controlling program
`timescale 1ns/1ps
`include "pptab_defs.svh"
module pptab_host (
	input  wire logic                     clk,
	output      logic [`PPTAB_ADDR_W-1:0] avs_address,
	output      logic                     avs_read,
	output      logic                     avs_write,
	output      logic [31:0]              avs_writedata,
	output      logic [3:0]               avs_byteenable,
	input  wire logic [31:0]              avs_readdata,
	input  wire logic                     avs_waitrequest
);
	// Idle bus from time zero
	initial begin
		avs_address = '0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		avs_byteenable = 4'h0;
	end

	// Write held until waitrequest is sampled low at a rising edge, released right after it
	task automatic wr(input logic [`PPTAB_ADDR_W-1:0] a, input logic [31:0] d, input logic [3:0] be);
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_byteenable <= be;
		avs_write <= 1'b1;
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		avs_write <= 1'b0;
		avs_writedata <= ~d; // Released data no longer shows old word
	endtask

	// Read data taken at the rising edge where waitrequest is sampled low
	task automatic rd(input logic [`PPTAB_ADDR_W-1:0] a, output logic [31:0] d);
		@(posedge clk);
		avs_address <= a;
		avs_read <= 1'b1;
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		d = avs_readdata;
		avs_read <= 1'b0;
	endtask
endmodule

// ---- tb/push_pop_word_table_bench.sv ----
// Self-checking bench of the push/pop word table
`timescale 1ns/1ps
`include "pptab_defs.svh"
module push_pop_word_table_bench;
	import pptab_pkg::*;
	logic                     clock;
	logic                     rst_n;
	logic [`PPTAB_ADDR_W-1:0] address;
	logic                     rd_en;
	logic                     wr_en;
	logic [31:0]              wdata;
	logic [3:0]               be;
	logic [31:0]              rdata;
	logic                     waitreq;
	logic                     irq;
	logic [31:0]              result;
	logic [4:0]               count;
	logic                     empty;
	logic                     full;
	logic [31:0]              got;
	int                       n_fail;
	int                       num_checks;
	int                       cycles;

	// ----------------------------------------------------------------
	// Clock, reset and hang guard
	// ----------------------------------------------------------------
	initial begin
		clock = 1'b0;
		rst_n = 1'b0;
		n_fail = 0;
		num_checks = 0;
		cycles = 0;
	end
	always #5 clock = ~clock;
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			n_fail++;
			summarize();
		end
	end

	// ----------------------------------------------------------------
	// Block and bus master
	// ----------------------------------------------------------------
	pptab_table i_pptab_table (
		.CLOCK(clock), .RST_N(rst_n), .AVS_ADDRESS(address), .AVS_READ(rd_en), .AVS_WRITE(wr_en),
		.AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be), .AVS_READDATA(rdata), .AVS_WAITREQUEST(waitreq),
		.IRQ(irq), .RESULT_OUT(result), .ENTRY_COUNT(count), .EMPTY_FLAG(empty), .FULL_FLAG(full)
	);
	pptab_host i_pptab_host (
		.clk(clock), .avs_address(address), .avs_read(rd_en), .avs_write(wr_en), .avs_writedata(wdata),
		.avs_byteenable(be), .avs_readdata(rdata), .avs_waitrequest(waitreq)
	);

	// ----------------------------------------------------------------
	// Compare and helper tasks
	// ----------------------------------------------------------------
	task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			n_fail++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chk_bit(input string nm, input logic e, input logic g);
		num_checks++;
		if (g !== e) begin
			n_fail++;
			$display("unexpected %s expected %b seen %b", nm, e, g);
		end
	endtask
	// Result, count and both fill flags at the ports
	task automatic chk_state(input logic [31:0] res, input logic [4:0] cnt);
		chk_word("result", res, result);
		chk_word("count", {27'h0, cnt}, {27'h0, count});
		chk_bit("empty", cnt == 5'h00, empty);
		chk_bit("full", cnt == 5'h10, full);
	endtask
	task automatic chk_reg(input string nm, input logic [`PPTAB_ADDR_W-1:0] a, input logic [31:0] e);
		i_pptab_host.rd(a, got);
		chk_word(nm, e, got);
	endtask
	// Raise coils, drop all but activation again, then let the operation land
	task automatic coil(input logic [4:0] bits);
		i_pptab_host.wr(`PPTAB_OFS_CTRL, {27'h0, bits}, 4'hf);
		i_pptab_host.wr(`PPTAB_OFS_CTRL, {31'h0, bits[0]}, 4'hf);
		repeat (2) @(negedge clock);
	endtask
	task automatic push(input logic [31:0] v);
		i_pptab_host.wr(`PPTAB_OFS_PUSHVAL, v, 4'hf);
		coil(5'h03);
	endtask
	function automatic logic [31:0] val(input int i);
		if (i == 0) return 32'h8000_0000;
		if (i == 1) return 32'h7fff_ffff;
		return 32'hc0de_0000 | 32'(i);
	endfunction
	task automatic summarize();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic s_reset();
		chk_state(32'h0, 5'h00);
		chk_bit("irq", 1'b0, irq);
		chk_reg("ctrl", `PPTAB_OFS_CTRL, 32'h0);
		chk_reg("push value", `PPTAB_OFS_PUSHVAL, 32'h0);
		chk_reg("irq enable", `PPTAB_OFS_IRQ_EN, 32'h0);
		chk_reg("irq clear", `PPTAB_OFS_IRQ_CLR, 32'h0);
	endtask
	// First push raises activation in the same write
	task automatic s_fill();
		for (int i = 0; i < 16; i++) begin
			push(val(i));
			chk_state(val(i), 5'(i + 1));
		end
		push(32'h0000_0055);
		chk_state(val(15), 5'h10);
		i_pptab_host.wr(`PPTAB_OFS_COUNT, 32'h0, 4'hf);
		chk_reg("count reg", `PPTAB_OFS_COUNT, 32'h10);
		chk_reg("result reg", `PPTAB_OFS_RESULT, val(15));
	endtask
	task automatic s_take();
		coil(5'h05);
		chk_state(val(0), 5'h0f);
		coil(5'h09);
		chk_state(val(15), 5'h0e);
		coil(5'h05);
		chk_state(val(1), 5'h0d);
	endtask
	task automatic s_flush();
		coil(5'h11);
		chk_state(val(1), 5'h00);
		chk_reg("flags", `PPTAB_OFS_FLAGS, 32'h1);
		chk_reg("irq status", `PPTAB_OFS_IRQ_ST, 32'h17);
	endtask
	// Refused take raises an interrupt that is masked and cleared
	task automatic s_irq();
		i_pptab_host.wr(`PPTAB_OFS_IRQ_CLR, 32'h1f, 4'h1);
		i_pptab_host.wr(`PPTAB_OFS_IRQ_EN, 32'h08, 4'h1);
		coil(5'h09);
		chk_state(val(1), 5'h00);
		chk_bit("irq", 1'b1, irq);
		chk_reg("irq status", `PPTAB_OFS_IRQ_ST, 32'h08);
		i_pptab_host.wr(`PPTAB_OFS_IRQ_EN, 32'h0, 4'h1);
		repeat (2) @(negedge clock);
		chk_bit("irq masked", 1'b0, irq);
		i_pptab_host.wr(`PPTAB_OFS_IRQ_EN, 32'h08, 4'h1);
		repeat (2) @(negedge clock);
		chk_bit("irq unmasked", 1'b1, irq);
		i_pptab_host.wr(`PPTAB_OFS_IRQ_CLR, 32'h08, 4'h1);
		repeat (2) @(negedge clock);
		chk_bit("irq cleared", 1'b0, irq);
		chk_reg("irq status", `PPTAB_OFS_IRQ_ST, 32'h0);
		i_pptab_host.wr(`PPTAB_OFS_PUSHVAL, 32'hffff_ffff, 4'hf);
		i_pptab_host.wr(`PPTAB_OFS_PUSHVAL, 32'h0, 4'h1);
		chk_reg("lane merge", `PPTAB_OFS_PUSHVAL, 32'hffff_ff00);
	endtask
	// Take edge with activation low, then take with activation rising
	task automatic s_disabled();
		push(32'h0000_0a01);
		push(32'h0000_0a02);
		chk_state(32'h0000_0a02, 5'h02);
		coil(5'h04);
		chk_state(32'h0000_0a02, 5'h02);
		coil(5'h05);
		chk_state(32'h0000_0a01, 5'h01);
		coil(5'h09);
		chk_state(32'h0000_0a02, 5'h00);
	endtask

	// Main sequence
	initial begin
		repeat (12) @(posedge clock);
		rst_n <= 1'b1;
		@(posedge clock);
		@(negedge clock);
		s_reset();
		s_fill();
		s_take();
		s_flush();
		s_irq();
		s_disabled();
		summarize();
	end
endmodule
